// file: asn_cpu_model.sv
// Purpose: CPU core model driving the arithmetic register port
// Assumes: One strobe per call, changed just after a rising edge
// Notes: Also stands in for the mul/div completion hook
`timescale 1ns/100ps
`default_nettype none
module asn_cpu_model (
   input wire logic clk,
   input wire logic [7:0] rdata,
   output var logic [2:0] addr,
   output var logic [7:0] wdata,
   output var logic wr,
   output var logic rd,
   output var logic muldiv_done,
   output var logic muldiv_ovf
);
   initial begin
      addr = 3'h7;
      wdata = 8'h00;
      wr = 1'b0;
      rd = 1'b0;
      muldiv_done = 1'b0;
      muldiv_ovf = 1'b0;
   end
   // ------------------------------------------
   // Bus cycles
   // ------------------------------------------
   task automatic wr_reg(input logic [2:0] a, input logic [7:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
      // Stale data is inverted so a late sample cannot pass
      wdata <= ~d;
   endtask
   task automatic rd_reg(input logic [2:0] a, output logic [7:0] d);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1;
      d = rdata;
   endtask
   task automatic md_done(input logic ovf);
      @(posedge clk);
      muldiv_done <= 1'b1;
      muldiv_ovf <= ovf;
      @(posedge clk);
      muldiv_done <= 1'b0;
      muldiv_ovf <= ~ovf;
   endtask
endmodule // asn_cpu_model
`default_nettype wire

// file: asn_pkg.sv
// Purpose: Shared constants for the shift and normalize unit
// Assumes: 8-bit register port, one clock
// Notes: Register offsets are register indices on the plain port
`default_nettype none
package asn_pkg;
   // --------------------------------------------------
   // Register map
   // --------------------------------------------------
   localparam logic [2:0] ADDR_OB0 = 3'h0;
   localparam logic [2:0] ADDR_OB1 = 3'h1;
   localparam logic [2:0] ADDR_OB2 = 3'h2;
   localparam logic [2:0] ADDR_OB3 = 3'h3;
   localparam logic [2:0] ADDR_OB4 = 3'h4;
   localparam logic [2:0] ADDR_OB5 = 3'h5;
   localparam logic [2:0] ADDR_CTRL = 3'h6;
   // --------------------------------------------------
   // Control register fields and reset values
   // --------------------------------------------------
   localparam int ERR_BIT = 7;
   localparam int OVF_BIT = 6;
   localparam int DIR_BIT = 5;
   localparam int CNT_W = 5;
   localparam logic [4:0] CNT_ZERO = 5'h00;
   localparam logic [4:0] NORM_MAX = 5'h1f;
   localparam logic [7:0] BYTE_RST = 8'h00;
   localparam logic [31:0] OP_RST = 32'h0000_0000;
   // --------------------------------------------------
   // Timing
   // --------------------------------------------------
   localparam logic [3:0] MC_CLKS = 4'hc;
   localparam logic [2:0] FIRST_STEPS = 3'h4;
   localparam logic [2:0] NEXT_STEPS = 3'h6;
   localparam int MAX_STEPS = 6;
   // --------------------------------------------------
   // States
   // --------------------------------------------------
   typedef enum logic [0:0] {
      ST_IDLE = 1'b0,
      ST_BUSY = 1'b1
   } asn_state_t;
endpackage
`default_nettype wire

// file: asn_shift_normalize.sv
// Purpose: Normalize/shift section and shared flags of the arithmetic unit
// Assumes: Core writes/reads operand bytes over a plain strobe port
// Notes: A machine cycle is a fixed count of core clocks
`timescale 1ns/100ps
`default_nettype none
// What this block does
// - Writing operand byte 0 resets the unit and arms monitoring.
// - Every control write launches an operation on operand bytes 0-3, except normalize with operand top bit already one.
// - Bytes 0-2 read in any order; byte 3 read disarms monitoring.
// - Normalize shifts the 32-bit operand left until its top bit is one or 31 shifts are done.
// - Count field zero in the control write selects normalize.
// - After normalize the count field holds shifts done, at most 31.
// - Normalize finishes within six machine cycles.
// - Bit 5 gives direction, bits 0-4 a nonzero shift count.
// - Direction one shifts right, zero shifts left.
// - Zeros enter at byte 0 on left shift, byte 3 on right.
// - Four bit-shifts first machine cycle, six in each later one.
// - Operand read or byte 0 rewrite during an operation sets error.
// - Overflow set on divide by zero, big product, or normalize top bit.
// - Non-overflow operations clear overflow; software cannot write it.
// - Mul/div: armed byte 0 rewrite sets error; byte 3 or 5 disarms.
// - Error flag is read-only and clears when read.
// - Illegal reads set error but never disturb the running operation.
module asn_shift_normalize (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [2:0] addr,
   input wire logic [7:0] wdata,
   input wire logic wr,
   input wire logic rd,
   input wire logic muldiv_done,
   input wire logic muldiv_ovf,
   output logic [7:0] rdata,
   output logic busy
);
   import asn_pkg::*;

   // --------------------------------------------------
   // Reset release
   // --------------------------------------------------
   logic rst_meta_reg;
   logic rst_sync_n;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rst_meta_reg <= 1'b0;
         rst_sync_n <= 1'b0;
      end else begin
         rst_meta_reg <= 1'b1;
         rst_sync_n <= rst_meta_reg;
      end
   end

   // --------------------------------------------------
   // Decode
   // --------------------------------------------------
   asn_state_t state_reg;
   logic [31:0] op_reg;
   logic [7:0] ob4_reg;
   logic [7:0] ob5_reg;
   logic [4:0] cnt_reg;
   logic [4:0] rem_reg;
   logic dir_reg;
   logic norm_reg;
   logic ovf_reg;
   logic err_reg;
   logic armed_reg;
   logic first_mc_reg;
   logic [3:0] mc_cnt_reg;
   logic [7:0] rdata_reg;
   logic wr_ctrl;
   logic wr_b0;
   logic rd_ctrl;
   logic rd_low;
   logic rd_end;
   logic norm_start;
   logic tick;
   logic err_set;
   logic [2:0] limit;
   logic [4:0] remaining;
   logic [31:0] step_value;
   logic [4:0] step_count;
   logic step_done;
   logic [7:0] ctrl_view;

   assign busy = (state_reg == ST_BUSY);
   assign wr_ctrl = wr && (addr == ADDR_CTRL);
   assign wr_b0 = wr && (addr == ADDR_OB0);
   assign rd_ctrl = rd && (addr == ADDR_CTRL);
   assign rd_low = rd && (addr <= ADDR_OB3);
   assign rd_end = rd && ((addr == ADDR_OB3) || (addr == ADDR_OB5));
   assign norm_start = wr_ctrl && (wdata[CNT_W-1:0] == CNT_ZERO);

   // --------------------------------------------------
   // Machine cycle divider
   // --------------------------------------------------
   // Restarted at launch so the first short step covers a full cycle
   always_ff @(posedge clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         mc_cnt_reg <= 4'h0;
      end else if (wr_ctrl || !busy || (mc_cnt_reg == MC_CLKS - 4'h1)) begin
         mc_cnt_reg <= 4'h0;
      end else begin
         mc_cnt_reg <= mc_cnt_reg + 4'h1;
      end
   end

   assign tick = busy && (mc_cnt_reg == MC_CLKS - 4'h1);

   always_ff @(posedge clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         first_mc_reg <= 1'b0;
      end else if (wr_ctrl) begin
         first_mc_reg <= 1'b1;
      end else if (tick) begin
         first_mc_reg <= 1'b0;
      end
   end

   // --------------------------------------------------
   // Shifter
   // --------------------------------------------------
   assign limit = first_mc_reg ? FIRST_STEPS : NEXT_STEPS;
   assign remaining = norm_reg ? (NORM_MAX - cnt_reg) : rem_reg;

   asn_shift_step u_step (
      .value_in(op_reg),
      .shift_right(dir_reg && !norm_reg),
      .normalize(norm_reg),
      .limit(limit),
      .remaining(remaining),
      .value_out(step_value),
      .steps(step_count),
      .finished(step_done)
   );

   // --------------------------------------------------
   // Sequencer
   // --------------------------------------------------
   always_ff @(posedge clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         state_reg <= ST_IDLE;
      end else if (wr_b0) begin
         state_reg <= ST_IDLE;
      end else if (wr_ctrl) begin
         // An operand already normalized needs no shifting at all
         if (norm_start && op_reg[31]) begin
            state_reg <= ST_IDLE;
         end else begin
            state_reg <= ST_BUSY;
         end
      end else if (tick && step_done) begin
         state_reg <= ST_IDLE;
      end
   end

   always_ff @(posedge clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         dir_reg <= 1'b0;
         norm_reg <= 1'b0;
      end else if (wr_ctrl) begin
         dir_reg <= wdata[DIR_BIT];
         norm_reg <= norm_start;
      end
   end

   always_ff @(posedge clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         cnt_reg <= CNT_ZERO;
         rem_reg <= CNT_ZERO;
      end else if (wr_ctrl) begin
         cnt_reg <= wdata[CNT_W-1:0];
         rem_reg <= wdata[CNT_W-1:0];
      end else if (tick && norm_reg) begin
         cnt_reg <= cnt_reg + step_count;
      end else if (tick) begin
         rem_reg <= rem_reg - step_count;
      end
   end

   // --------------------------------------------------
   // Operand bytes
   // --------------------------------------------------
   // Bytes 1-3 are locked while busy so a stray write cannot corrupt it
   always_ff @(posedge clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         op_reg <= OP_RST;
      end else if (wr_b0) begin
         op_reg[7:0] <= wdata;
      end else if (wr && !busy && (addr == ADDR_OB1)) begin
         op_reg[15:8] <= wdata;
      end else if (wr && !busy && (addr == ADDR_OB2)) begin
         op_reg[23:16] <= wdata;
      end else if (wr && !busy && (addr == ADDR_OB3)) begin
         op_reg[31:24] <= wdata;
      end else if (tick) begin
         op_reg <= step_value;
      end
   end

   always_ff @(posedge clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         ob4_reg <= BYTE_RST;
         ob5_reg <= BYTE_RST;
      end else if (wr && (addr == ADDR_OB4)) begin
         ob4_reg <= wdata;
      end else if (wr && (addr == ADDR_OB5)) begin
         ob5_reg <= wdata;
      end
   end

   // --------------------------------------------------
   // Flags
   // --------------------------------------------------
   always_ff @(posedge clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         ovf_reg <= 1'b0;
      end else if (wr_ctrl) begin
         ovf_reg <= norm_start && op_reg[31];
      end else if (muldiv_done) begin
         ovf_reg <= muldiv_ovf;
      end
   end

   always_ff @(posedge clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         armed_reg <= 1'b0;
      end else if (wr_b0) begin
         armed_reg <= 1'b1;
      end else if (rd_end) begin
         armed_reg <= 1'b0;
      end
   end

   assign err_set = (armed_reg && wr_b0)
      || (busy && (rd_low || wr_b0));

   // Set wins over the clearing read
   always_ff @(posedge clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         err_reg <= 1'b0;
      end else if (err_set) begin
         err_reg <= 1'b1;
      end else if (rd_ctrl) begin
         err_reg <= 1'b0;
      end
   end

   // --------------------------------------------------
   // Read port
   // --------------------------------------------------
   assign ctrl_view = {err_reg, ovf_reg, dir_reg, cnt_reg};

   always_ff @(posedge clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         rdata_reg <= BYTE_RST;
      end else if (rd) begin
         case (addr)
            ADDR_OB0: rdata_reg <= op_reg[7:0];
            ADDR_OB1: rdata_reg <= op_reg[15:8];
            ADDR_OB2: rdata_reg <= op_reg[23:16];
            ADDR_OB3: rdata_reg <= op_reg[31:24];
            ADDR_OB4: rdata_reg <= ob4_reg;
            ADDR_OB5: rdata_reg <= ob5_reg;
            ADDR_CTRL: rdata_reg <= ctrl_view;
            default: rdata_reg <= BYTE_RST;
         endcase
      end else begin
         rdata_reg <= BYTE_RST;
      end
   end

   assign rdata = rdata_reg;

   // --------------------------------------------------
   // Checks
   // --------------------------------------------------
   logic [6:0] busy_len_reg;

   always_ff @(posedge clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         busy_len_reg <= 7'h00;
      end else if (!busy || wr_ctrl) begin
         busy_len_reg <= 7'h00;
      end else begin
         busy_len_reg <= busy_len_reg + 7'h01;
      end
   end

   a_arm_on_b0: assert property (
      @(posedge clk) disable iff (!rst_sync_n)
      wr_b0 |=> armed_reg && !busy)
      else $error("byte 0 write did not reset and arm");

   a_launch_busy: assert property (
      @(posedge clk) disable iff (!rst_sync_n)
      wr_ctrl && !norm_start |=> busy)
      else $error("control write did not launch");

   a_disarm_b3: assert property (
      @(posedge clk) disable iff (!rst_sync_n)
      rd && (addr == ADDR_OB3) && !wr_b0 |=> !armed_reg)
      else $error("byte 3 read did not disarm");

   a_norm_result: assert property (
      @(posedge clk) disable iff (!rst_sync_n)
      $fell(busy) && norm_reg && !$past(wr_b0)
      |-> op_reg[31] || (cnt_reg == NORM_MAX))
      else $error("normalize ended with top bit zero");

   a_busy_bound: assert property (
      @(posedge clk) disable iff (!rst_sync_n)
      busy_len_reg <= 7'h48)
      else $error("operation exceeded six machine cycles");

   a_first_four: assert property (
      @(posedge clk) disable iff (!rst_sync_n)
      tick && first_mc_reg |-> step_count <= 5'h04)
      else $error("first machine cycle shifted over four");

   // Direction taken from the tick cycle, a control write may follow it
   a_zero_fill: assert property (
      @(posedge clk) disable iff (!rst_sync_n)
      tick && !norm_reg && !wr_b0 && (step_count != 5'h00)
      |=> ($past(dir_reg) ? !op_reg[31] : !op_reg[0]))
      else $error("vacated bit not zero");

   a_early_read: assert property (
      @(posedge clk) disable iff (!rst_sync_n)
      busy && rd_low |=> err_reg)
      else $error("early read did not set error");

   a_ovf_norm: assert property (
      @(posedge clk) disable iff (!rst_sync_n)
      norm_start |=> ovf_reg == $past(op_reg[31]))
      else $error("normalize overflow wrong");

   // Read data stand in the cycle after the read and show the old flag
   a_err_clear: assert property (
      @(posedge clk) disable iff (!rst_sync_n)
      rd_ctrl && !err_set |=> !err_reg && (rdata[ERR_BIT] == $past(err_reg)))
      else $error("error flag not cleared by read");
endmodule // asn_shift_normalize
`default_nettype wire

// file: asn_shift_step.sv
// Purpose: One machine cycle worth of shifting
// Assumes: Pure combinational, up to six single-bit steps
// Notes: Stops early on count reached or, when normalizing, on top bit one
`timescale 1ns/100ps
`default_nettype none
module asn_shift_step (
   input wire logic [31:0] value_in,
   input wire logic shift_right,
   input wire logic normalize,
   input wire logic [2:0] limit,
   input wire logic [4:0] remaining,
   output logic [31:0] value_out,
   output logic [4:0] steps,
   output logic finished
);
   import asn_pkg::*;

   always_comb begin
      logic [31:0] v;
      logic [4:0] n;
      logic stop;
      v = value_in;
      n = 5'h00;
      stop = 1'b0;
      for (int i = 0; i < MAX_STEPS; i++) begin
         stop = (n == remaining) || (normalize && v[31]);
         if ((3'(i) < limit) && !stop) begin
            // Zeros enter at the vacated end
            v = shift_right ? {1'b0, v[31:1]} : {v[30:0], 1'b0};
            n = n + 5'h01;
         end
      end
      value_out = v;
      steps = n;
      finished = (n == remaining) || (normalize && v[31]);
   end
endmodule // asn_shift_step
`default_nettype wire

// file: testbench.sv
// Purpose: Self-checking bench for the shift and normalize unit
// Assumes: CPU model does all bus cycles
// Notes: Expected values are computed here from the operand
`timescale 1ns/100ps
`default_nettype none
module testbench;
   import asn_pkg::*;
   logic clk;
   logic rst_n;
   logic [2:0] addr;
   logic [7:0] wdata;
   logic wr;
   logic rd;
   logic muldiv_done;
   logic muldiv_ovf;
   logic [7:0] rdata;
   logic busy;
   int error_cnt = 0;
   int check_count = 0;

   asn_shift_normalize dut (.clk(clk), .rst_n(rst_n), .addr(addr),
      .wdata(wdata), .wr(wr), .rd(rd), .muldiv_done(muldiv_done),
      .muldiv_ovf(muldiv_ovf), .rdata(rdata), .busy(busy));
   asn_cpu_model cpu (.clk(clk), .rdata(rdata), .addr(addr),
      .wdata(wdata), .wr(wr), .rd(rd), .muldiv_done(muldiv_done),
      .muldiv_ovf(muldiv_ovf));

   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   // ------------------------------------------
   // Helpers
   // ------------------------------------------
   task automatic complete_run;
      $display("checks %0d mismatches %0d", check_count, error_cnt);
      if (error_cnt == 0 && check_count > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   task automatic check(input string what, input logic [31:0] seen,
                        input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         error_cnt++;
         $display("[FAIL] %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic load(input logic [31:0] v);
      for (int i = 0; i < 4; i++) begin
         cpu.wr_reg(3'(i), v[8*i +: 8]);
      end
   endtask
   task automatic rd_op(output logic [31:0] v);
      logic [7:0] b;
      for (int i = 0; i < 4; i++) begin
         cpu.rd_reg(3'(i), b);
         v[8*i +: 8] = b;
      end
   endtask
   task automatic wait_idle(output int n);
      n = 0;
      #1;
      while (busy === 1'b1 && n < 200) begin
         @(posedge clk);
         #1;
         n++;
      end
      check("busy end", busy, 1'b0);
      // Result treated as valid only a machine cycle later
      repeat (12) @(posedge clk);
   endtask
   task automatic go(input logic [7:0] c, output int n);
      cpu.wr_reg(ADDR_CTRL, c);
      wait_idle(n);
   endtask
   task automatic do_shift(input logic [7:0] c, input logic [31:0] op);
      int n;
      int k;
      logic [31:0] got;
      logic [7:0] b;
      k = c[4:0];
      load(op);
      go(c, n);
      rd_op(got);
      check("shift result", got, c[5] ? op >> k : op << k);
      cpu.rd_reg(ADDR_CTRL, b);
      check("shift ctrl", b[5:0], c[5:0]);
      check("shift flags", b[7:6], 2'b00);
      check("shift time", n, 12 * ((k <= 4) ? 1 : (k + 1) / 6 + 1));
      $display("test shift %h done", c);
   endtask
   function automatic int lzc(input logic [31:0] v);
      int k = 0;
      while (k < 31 && v[31-k] == 1'b0) k++;
      return k;
   endfunction
   // ------------------------------------------
   // Tests
   // ------------------------------------------
   initial begin
      logic [7:0] b;
      logic [31:0] got;
      logic [31:0] nv [2];
      int n;
      nv = '{32'h0000_1234, 32'h0000_0000};
      rst_n = 1'b0;
      repeat (4) @(posedge clk);
      rst_n <= 1'b1;
      repeat (3) @(posedge clk);
      check("busy reset", busy, 1'b0);
      cpu.rd_reg(ADDR_CTRL, b);
      check("ctrl reset", b, 8'h00);
      cpu.rd_reg(3'h7, b);
      check("unmapped", b, 8'h00);
      $display("test reset done");
      do_shift(8'h04, 32'h1234_5678);
      do_shift(8'h05, 32'hF000_000F);
      do_shift(8'h2A, 32'h8765_4321);
      do_shift(8'h3F, 32'hFFFF_FFFF);
      foreach (nv[i]) begin
         load(nv[i]);
         go(8'h00, n);
         rd_op(got);
         check("norm result", got, nv[i] << lzc(nv[i]));
         cpu.rd_reg(ADDR_CTRL, b);
         check("norm count", b, 8'(lzc(nv[i])));
         check("norm time", n <= 72, 1'b1);
      end
      $display("test normalize done");
      load(32'h8000_0001);
      go(8'h00, n);
      cpu.rd_reg(ADDR_CTRL, b);
      check("norm top ovf", b, 8'h40);
      rd_op(got);
      check("norm top op", got, 32'h8000_0001);
      go(8'hC4, n);
      cpu.rd_reg(ADDR_CTRL, b);
      check("ovf cleared", b, 8'h04);
      cpu.md_done(1'b1);
      cpu.rd_reg(ADDR_CTRL, b);
      check("md ovf set", b, 8'h44);
      cpu.md_done(1'b0);
      cpu.rd_reg(ADDR_CTRL, b);
      check("md ovf clr", b, 8'h04);
      $display("test overflow done");
      load(32'h8000_0000);
      cpu.wr_reg(ADDR_CTRL, 8'h3F);
      cpu.rd_reg(ADDR_OB1, b);
      wait_idle(n);
      rd_op(got);
      check("early read op", got, 32'h0000_0001);
      cpu.rd_reg(ADDR_CTRL, b);
      check("early read err", b, 8'hBF);
      cpu.rd_reg(ADDR_CTRL, b);
      check("err self clear", b, 8'h3F);
      cpu.wr_reg(ADDR_OB0, 8'h11);
      cpu.wr_reg(ADDR_OB0, 8'h22);
      cpu.rd_reg(ADDR_CTRL, b);
      check("rewrite err", b[7], 1'b1);
      cpu.rd_reg(ADDR_OB3, b);
      cpu.wr_reg(ADDR_OB0, 8'h33);
      cpu.rd_reg(ADDR_CTRL, b);
      check("disarmed", b[7], 1'b0);
      $display("test error flag done");
      // Byte 3 write while busy must be ignored; direction bit not used
      cpu.rd_reg(ADDR_OB3, b);
      load(32'h0000_0001);
      cpu.wr_reg(ADDR_CTRL, 8'h20);
      cpu.wr_reg(ADDR_OB3, 8'hAA);
      wait_idle(n);
      rd_op(got);
      check("norm dir op", got, 32'h8000_0000);
      cpu.rd_reg(ADDR_CTRL, b);
      check("norm dir ctrl", b, 8'h3F);
      // Byte 0 rewrite before the first tick aborts the shift
      cpu.wr_reg(ADDR_CTRL, 8'h3F);
      cpu.wr_reg(ADDR_OB0, 8'h5A);
      wait_idle(n);
      check("abort time", n, 0);
      rd_op(got);
      check("abort op", got, 32'h8000_005A);
      cpu.rd_reg(ADDR_CTRL, b);
      check("rewrite busy err", b, 8'hBF);
      $display("test abort done");
      complete_run();
   end

   // Whole run is under 2000 clocks; the limit leaves wide margin
   initial begin
      #125000;
      error_cnt++;
      complete_run();
   end
endmodule // testbench
`default_nettype wire
